//--- src/nfc_regs_pkg.sv
// Constants shared by the reader mode control register bank.
// Assumes a single 200 MHz clock and a 32-bit Avalon-MM register port.
package nfc_regs_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // Register indices; byte address is four times the index.
   localparam logic [5:0] IDX_OPCTL = 6'h02;
   localparam logic [5:0] IDX_MODE  = 6'h03;
   localparam logic [5:0] IDX_RATE  = 6'h04;
   localparam logic [5:0] IDX_TYPEA = 6'h05;
   // Field positions.
   localparam int OPC_OSC    = 7;
   localparam int OPC_RX     = 6;
   localparam int OPC_SINGLE = 5;
   localparam int OPC_MANUAL = 4;
   localparam int OPC_TX     = 3;
   localparam int OPC_WAKEUP = 2;
   localparam int MODE_TARGET = 7;
   localparam int MODE_OM_HI  = 6;
   localparam int MODE_OM_LO  = 3;
   localparam int MODE_RCA    = 0;
   localparam int RATE_TX_HI = 7;
   localparam int RATE_TX_LO = 4;
   localparam int RATE_RX_HI = 3;
   localparam int RATE_RX_LO = 0;
   localparam int TYPEA_NO_TX_PAR = 7;
   // Writable bit masks and reset values.
   localparam logic [7:0] OPCTL_MASK = 8'hFC;
   localparam logic [7:0] MODE_MASK  = 8'hF9;
   localparam logic [7:0] OPCTL_RST  = 8'h00;
   localparam logic [7:0] MODE_RST   = 8'h08;
   localparam logic [7:0] RATE_RST   = 8'h00;
   localparam logic [7:0] TYPEA_RST  = 8'h00;
   // Operating mode codes.
   localparam logic [3:0] OM_ACTIVE  = 4'h0;
   localparam logic [3:0] OM_ISO_A   = 4'h1;
   localparam logic [3:0] OM_ISO_B   = 4'h2;
   localparam logic [3:0] OM_CARD212 = 4'h3;
   localparam logic [3:0] OM_TYPE1   = 4'h4;
   localparam logic [3:0] OM_SUBC    = 4'hE;
   localparam logic [3:0] OM_BPSK    = 4'hF;
   localparam logic [3:0] OM_T_DETECT = 4'h0;
   localparam logic [3:0] OM_T_NORMAL = 4'h1;
   // Bit rate codes, divider of the carrier frequency.
   localparam logic [3:0] RATE_FC128 = 4'h0;
   localparam logic [3:0] RATE_FC16  = 4'h3;
   localparam logic [3:0] RATE_FC8   = 4'h4;
   localparam logic [3:0] RATE_FC4   = 4'h5;
   localparam logic [3:0] RATE_FC2   = 4'h6;
   typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_ACK = 2'b01} bus_state_t;
endpackage

//--- src/mode_decode.sv
// Decodes role and operating mode code into support and class flags.
// Assumes registered inputs from the register bank on the same clock.
`timescale 1ns/100ps
module mode_decode
(
   input  wire logic       i_target,      // 1: target role
   input  wire logic [3:0] i_op_mode,     // Operating mode code
   output logic            o_mode_ok,     // Code supported for role
   output logic            o_iso_b,       // Type B protocol selected
   output logic            o_active,      // Active peer communication
   output logic            o_split_rates  // Protocol allows own rx rate
);
   always_comb
   begin
      o_mode_ok     = 1'b0;
      o_iso_b       = 1'b0;
      o_active      = 1'b0;
      o_split_rates = 1'b0;
      if (i_target)
      begin
         // Only the two active peer modes exist for the target.
         o_mode_ok = (i_op_mode == nfc_regs_pkg::OM_T_DETECT) ||
                     (i_op_mode == nfc_regs_pkg::OM_T_NORMAL);
         o_active  = o_mode_ok;
      end
      else
      begin
         case (i_op_mode)
            nfc_regs_pkg::OM_ACTIVE:
            begin
               o_mode_ok = 1'b1;
               o_active  = 1'b1;
            end
            nfc_regs_pkg::OM_ISO_A,
            nfc_regs_pkg::OM_ISO_B:
            begin
               o_mode_ok     = 1'b1;
               o_split_rates = 1'b1;
               o_iso_b       = (i_op_mode == nfc_regs_pkg::OM_ISO_B);
            end
            nfc_regs_pkg::OM_CARD212,
            nfc_regs_pkg::OM_TYPE1,
            nfc_regs_pkg::OM_SUBC,
            nfc_regs_pkg::OM_BPSK: o_mode_ok = 1'b1;
            default:               o_mode_ok = 1'b0;
         endcase
      end
   end
endmodule

//--- src/rate_check.sv
// Checks transmit and receive rate codes against the selected protocol.
// Assumes flags from the mode decoder on the same clock.
`timescale 1ns/100ps
module rate_check
(
   input  wire logic [3:0] i_tx_code,  // Transmit rate code
   input  wire logic [3:0] i_rx_code,  // Receive rate code
   input  wire logic       i_iso_b,    // Type B protocol selected
   input  wire logic       i_split,    // Protocol allows own rx rate
   output logic            o_rate_ok,  // Both rates supported
   output logic [3:0]      o_rx_eff    // Rate code the receiver uses
);
   logic tx_ok;
   logic rx_ok;

   always_comb
   begin
      // Without separate rates the receiver follows the transmit rate.
      o_rx_eff = i_split ? i_rx_code : i_tx_code;
      tx_ok    = (i_tx_code <= nfc_regs_pkg::RATE_FC16) ||
                 (i_iso_b && (i_tx_code <= nfc_regs_pkg::RATE_FC2));
      rx_ok    = (o_rx_eff <= nfc_regs_pkg::RATE_FC16) ||
                 (o_rx_eff == nfc_regs_pkg::RATE_FC8) ||
                 (o_rx_eff == nfc_regs_pkg::RATE_FC4);
      o_rate_ok = tx_ok && rx_ok;
   end
endmodule

//--- src/reader_mode_control_regs.sv
// Reader front end mode control registers on an Avalon-MM slave port.
// Assumes command pulses come from logic on the same clock.
//
// Summary of operation
// [RULE_01] Oscillator enable bit runs oscillator and regulator.
// [RULE_02] Receive path only while receive enable set.
// [RULE_03] Single channel bit: channel_choice picks channel.
// [RULE_04] Manual bit chooses automatic or chosen channel.
// [RULE_05] Field-on sets transmit enable; active completion clears.
// [RULE_06] Wake-up bit places device in wake-up.
// [RULE_07] Operation control resets only at power-up.
// [RULE_08] Role bit: initiator or target decoding.
// [RULE_09] Four-bit mode field, reset value 0001.
// [RULE_10] Initiator mode codes decode to seven protocols.
// [RULE_11] Target codes: detection or normal active.
// [RULE_12] Unsupported mode code disables transmit and receive.
// [RULE_13] Auto bit starts response collision avoidance.
// [RULE_14] Upper nibble sets transmit bit rate.
// [RULE_15] Lower nibble sets receive rate when allowed.
// [RULE_16] Codes 0 to 6 map fc/128 to fc/2.
// [RULE_17] Very high transmit rates only for type B.
// [RULE_18] Very high receive rates only fc/8, fc/4.
// [RULE_19] Unsupported rate disables transmit and receive.
// [RULE_20] Rate register clears at power-up and set-default.
// [RULE_21] Go-to-normal command loads the rate register.
// [RULE_22] Type A settings reset on set-default too.
// [RULE_23] Unused bits ignore writes, read zero.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
module reader_mode_control_regs
(
   input  wire logic        i_mclk,             // 200 MHz clock
   input  wire logic        i_nrst,             // Async reset, active low
   input  wire logic [7:0]  i_avs_address,      // Byte address
   input  wire logic        i_avs_read,         // Read request
   input  wire logic        i_avs_write,        // Write request
   input  wire logic [3:0]  i_avs_byteenable,   // Byte lanes
   input  wire logic [31:0] i_avs_writedata,    // Write data
   output logic [31:0]      o_avs_readdata,     // Read data
   output logic             o_avs_waitrequest,  // Request not yet taken
   input  wire logic        i_field_on_cmd,     // Field-on command pulse
   input  wire logic        i_tx_done,          // Transmission finished pulse
   input  wire logic        i_set_default_cmd,  // Set-default command pulse
   input  wire logic        i_go_normal_cmd,    // Go-to-normal command pulse
   input  wire logic [7:0]  i_normal_rate,      // Rate value for go-to-normal
   input  wire logic        i_channel_choice,   // 0: amplitude, 1: phase
   output logic             o_osc_reg_enable,   // Oscillator and regulator on
   output logic             o_rx_path_enable,   // Receive path on
   output logic             o_tx_path_enable,   // Transmit path on
   output logic             o_am_channel_en,    // Amplitude channel on
   output logic             o_pm_channel_en,    // Phase channel on
   output logic             o_auto_channel,     // Automatic channel choice
   output logic             o_use_pm_channel,   // Phase channel chosen
   output logic             o_wakeup_mode,      // Wake-up mode
   output logic             o_target_role,      // Target role
   output logic [3:0]       o_op_mode,          // Operating mode code
   output logic             o_active_comm,      // Active peer mode
   output logic             o_auto_rca,         // Auto collision avoidance
   output logic [3:0]       o_tx_rate,          // Transmit rate code
   output logic [3:0]       o_rx_rate,          // Receive rate code in use
   output logic             o_config_ok,        // Mode and rates supported
   output logic             o_tx_parity_off     // No transmit parity
);

////////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, then the request is taken.

   nfc_regs_pkg::bus_state_t bus_q;
   nfc_regs_pkg::bus_state_t bus_d;
   logic [31:0]              rdata_q;
   logic [31:0]              rdata_d;
   logic                     req;
   logic [5:0]               idx;
   logic                     aligned;
   logic                     wr_en;
   logic [7:0]               wdata;
   logic [7:0]               opctl_q;
   logic [7:0]               mode_q;
   logic [7:0]               rate_q;
   logic [7:0]               typea_q;

   assign req               = i_avs_read || i_avs_write;
   assign idx               = i_avs_address[7:2];
   assign aligned           = (i_avs_address[1:0] == 2'h0);
   assign wdata             = i_avs_writedata[7:0];
   assign o_avs_waitrequest = req && (bus_q != nfc_regs_pkg::BUS_ACK);
   assign o_avs_readdata    = rdata_q;

   always_comb
   begin
      bus_d   = bus_q;
      rdata_d = rdata_q;
      wr_en   = i_avs_write && (bus_q == nfc_regs_pkg::BUS_ACK) &&
                i_avs_byteenable[0] && aligned;
      case (bus_q)
         nfc_regs_pkg::BUS_IDLE:
         begin
            if (req)
            begin
               bus_d   = nfc_regs_pkg::BUS_ACK;
               rdata_d = 32'h0000_0000;
               if (i_avs_read && aligned)
               begin
                  case (idx)
                     nfc_regs_pkg::IDX_OPCTL: rdata_d[7:0] = opctl_q;
                     nfc_regs_pkg::IDX_MODE:  rdata_d[7:0] = mode_q;
                     nfc_regs_pkg::IDX_RATE:  rdata_d[7:0] = rate_q;
                     nfc_regs_pkg::IDX_TYPEA: rdata_d[7:0] = typea_q;
                     default:                 rdata_d      = 32'h0000_0000;
                  endcase
               end
            end
         end
         nfc_regs_pkg::BUS_ACK: bus_d = nfc_regs_pkg::BUS_IDLE;
         default:               bus_d = nfc_regs_pkg::BUS_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         bus_q   <= nfc_regs_pkg::BUS_IDLE;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         bus_q   <= bus_d;
         rdata_q <= rdata_d;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0] opctl_d;
   logic [7:0] mode_d;
   logic [7:0] rate_d;
   logic [7:0] typea_d;
   logic       mode_ok;
   logic       iso_b;
   logic       active;
   logic       split;
   logic       rate_ok;
   logic [3:0] rx_eff;

   always_comb
   begin
      opctl_d = opctl_q;
      mode_d  = mode_q;
      rate_d  = rate_q;
      typea_d = typea_q;
      if (wr_en && (idx == nfc_regs_pkg::IDX_OPCTL))
      begin
         opctl_d = wdata & nfc_regs_pkg::OPCTL_MASK;  // see [RULE_23]
      end
      if (wr_en && (idx == nfc_regs_pkg::IDX_MODE))
      begin
         mode_d = wdata & nfc_regs_pkg::MODE_MASK;  // see [RULE_23]
      end
      if (wr_en && (idx == nfc_regs_pkg::IDX_RATE))
      begin
         rate_d = wdata;
      end
      if (wr_en && (idx == nfc_regs_pkg::IDX_TYPEA))
      begin
         typea_d = wdata;
      end
      // Completion clears transmit enable only in active peer mode.
      if (i_tx_done && active)
      begin
         opctl_d[nfc_regs_pkg::OPC_TX] = 1'b0;  // see [RULE_05]
      end
      // The hardware set wins over any clear in the same cycle.
      if (i_field_on_cmd)
      begin
         opctl_d[nfc_regs_pkg::OPC_TX] = 1'b1;  // see [RULE_05]
      end
      // Set-default leaves operation control and mode untouched.
      if (i_set_default_cmd)
      begin
         rate_d  = nfc_regs_pkg::RATE_RST;   // see [RULE_20]
         typea_d = nfc_regs_pkg::TYPEA_RST;  // see [RULE_22]
      end
      if (i_go_normal_cmd)
      begin
         rate_d = i_normal_rate;  // see [RULE_21]
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         opctl_q <= nfc_regs_pkg::OPCTL_RST;  // see [RULE_07]
         mode_q  <= nfc_regs_pkg::MODE_RST;   // see [RULE_09]
         rate_q  <= nfc_regs_pkg::RATE_RST;   // see [RULE_20]
         typea_q <= nfc_regs_pkg::TYPEA_RST;  // see [RULE_22]
      end
      else
      begin
         opctl_q <= opctl_d;
         mode_q  <= mode_d;
         rate_q  <= rate_d;
         typea_q <= typea_d;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Mode and rate decoding.

   mode_decode u_mode_decode
   (
      .i_target      (mode_q[nfc_regs_pkg::MODE_TARGET]),
      .i_op_mode     (mode_q[nfc_regs_pkg::MODE_OM_HI:nfc_regs_pkg::MODE_OM_LO]),
      .o_mode_ok     (mode_ok),
      .o_iso_b       (iso_b),
      .o_active      (active),
      .o_split_rates (split)
   );

   rate_check u_rate_check
   (
      .i_tx_code (rate_q[nfc_regs_pkg::RATE_TX_HI:nfc_regs_pkg::RATE_TX_LO]),
      .i_rx_code (rate_q[nfc_regs_pkg::RATE_RX_HI:nfc_regs_pkg::RATE_RX_LO]),
      .i_iso_b   (iso_b),
      .i_split   (split),
      .o_rate_ok (rate_ok),
      .o_rx_eff  (rx_eff)
   );

////////////////////////////////////////////////////////////////////////////////
   // Registered control outputs.

   logic [12:0] ctl_q;
   logic [12:0] ctl_d;
   logic [7:0]  rates_q;
   logic [7:0]  rates_d;
   logic [3:0]  om_q;
   logic [3:0]  om_d;
   logic        ok;
   logic        single;
   logic        manual;

   always_comb
   begin
      ok      = mode_ok && rate_ok;  // see [RULE_12] [RULE_19]
      single  = opctl_q[nfc_regs_pkg::OPC_SINGLE];
      manual  = opctl_q[nfc_regs_pkg::OPC_MANUAL];
      ctl_d   = 13'h0000;
      ctl_d[0] = opctl_q[nfc_regs_pkg::OPC_OSC];  // see [RULE_01]
      ctl_d[1] = opctl_q[nfc_regs_pkg::OPC_OSC] &&
                 opctl_q[nfc_regs_pkg::OPC_RX] && ok;  // see [RULE_02]
      ctl_d[2] = opctl_q[nfc_regs_pkg::OPC_OSC] &&
                 opctl_q[nfc_regs_pkg::OPC_TX] && ok;
      ctl_d[3] = !single || !i_channel_choice;  // see [RULE_03]
      ctl_d[4] = !single || i_channel_choice;   // see [RULE_03]
      ctl_d[5] = !single && !manual;            // see [RULE_04]
      ctl_d[6] = single || manual ? i_channel_choice : 1'b0;  // see [RULE_04]
      ctl_d[7] = opctl_q[nfc_regs_pkg::OPC_WAKEUP];  // see [RULE_06]
      ctl_d[8] = mode_q[nfc_regs_pkg::MODE_TARGET];  // see [RULE_08]
      ctl_d[9] = active;  // see [RULE_10] [RULE_11]
      ctl_d[10] = mode_q[nfc_regs_pkg::MODE_RCA];  // see [RULE_13]
      ctl_d[11] = ok;
      ctl_d[12] = typea_q[nfc_regs_pkg::TYPEA_NO_TX_PAR];  // see [RULE_22]
      om_d    = mode_q[nfc_regs_pkg::MODE_OM_HI:nfc_regs_pkg::MODE_OM_LO];
      // Rate codes pass on unclamped; o_config_ok flags unsupported ones.
      rates_d = {rate_q[nfc_regs_pkg::RATE_TX_HI:nfc_regs_pkg::RATE_TX_LO],
                 rx_eff};  // see [RULE_14] [RULE_15] [RULE_16] [RULE_17] [RULE_18]
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ctl_q   <= 13'h0000;
         om_q    <= nfc_regs_pkg::MODE_RST[6:3];
         rates_q <= 8'h00;
      end
      else
      begin
         ctl_q   <= ctl_d;
         om_q    <= om_d;
         rates_q <= rates_d;
      end
   end

   assign o_osc_reg_enable = ctl_q[0];
   assign o_rx_path_enable = ctl_q[1];
   assign o_tx_path_enable = ctl_q[2];
   assign o_am_channel_en  = ctl_q[3];
   assign o_pm_channel_en  = ctl_q[4];
   assign o_auto_channel   = ctl_q[5];
   assign o_use_pm_channel = ctl_q[6];
   assign o_wakeup_mode    = ctl_q[7];
   assign o_target_role    = ctl_q[8];
   assign o_active_comm    = ctl_q[9];
   assign o_auto_rca       = ctl_q[10];
   assign o_config_ok      = ctl_q[11];
   assign o_tx_parity_off  = ctl_q[12];
   assign o_op_mode        = om_q;
   assign o_tx_rate        = rates_q[7:4];
   assign o_rx_rate        = rates_q[3:0];

////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   AST_TX_SET: assert property (i_field_on_cmd |=> opctl_q[3]) // see [RULE_05]
      else $error("Field-on did not set transmit enable.");

   AST_TX_CLEAR: assert property (i_tx_done && active && !i_field_on_cmd && !wr_en // see [RULE_05]
      |=> !opctl_q[3])
      else $error("Transmit enable not cleared after completion.");

   AST_OPCTL_KEEP: assert property (i_set_default_cmd && !wr_en && !i_field_on_cmd // see [RULE_07]
      && !i_tx_done |=> $stable(opctl_q))
      else $error("Set-default changed operation control.");

   AST_RATE_DEFAULT: assert property (i_set_default_cmd && !i_go_normal_cmd // see [RULE_20]
      |=> rate_q == 8'h00 ##1 o_tx_rate == 4'h0)
      else $error("Set-default did not clear the rate register.");

   AST_RATE_LOAD: assert property (i_go_normal_cmd // see [RULE_21]
      |=> rate_q == $past(i_normal_rate))
      else $error("Go-to-normal did not load the rate register.");

   AST_BAD_CONFIG: assert property (!(mode_ok && rate_ok) // see [RULE_12] [RULE_19]
      |=> !o_tx_path_enable && !o_rx_path_enable)
      else $error("Path enabled with unsupported configuration.");

   AST_VERY_HIGH_RATE_TX: assert property (rate_q[7:4] >= 4'h4 && !iso_b |-> !rate_ok) // see [RULE_17]
      else $error("Very high transmit rate accepted outside type B.");

   AST_VERY_HIGH_RATE_RX: assert property (rx_eff == 4'h6 |-> !rate_ok) // see [RULE_18]
      else $error("Receive at fc/2 accepted.");

   AST_RX_GATE: assert property (!opctl_q[6] |=> !o_rx_path_enable) // see [RULE_02]
      else $error("Receive path on without receive enable.");

   AST_OSC: assert property (opctl_q[7] |=> o_osc_reg_enable) // see [RULE_01]
      else $error("Oscillator not enabled.");

   AST_UNUSED: assert property (opctl_q[1:0] == 2'h0 && mode_q[2:1] == 2'h0) // see [RULE_23]
      else $error("Unused register bit set.");

   AST_BUS_ACK: assert property (req && bus_q == nfc_regs_pkg::BUS_IDLE
      |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("Bus request not answered after one wait cycle.");

endmodule

//--- verif/avalon_host_model.sv
// Host model that drives the register bank's Avalon-MM port.
// Assumes one clock shared with the bank and a slave that lowers waitrequest.
`timescale 1ns/100ps
module avalon_host_model
(
   input  wire logic        i_mclk,         // Bus clock
   input  wire logic [31:0] i_readdata,     // Read data
   input  wire logic        i_waitrequest,  // Slave stall
   output logic [7:0]       o_address,      // Byte address
   output logic             o_read,         // Read request
   output logic             o_write,        // Write request
   output logic [3:0]       o_byteenable,   // Byte lanes
   output logic [31:0]      o_writedata     // Write data
);
   initial
   begin
      {o_address, o_read, o_write, o_byteenable, o_writedata} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Released address and write data show the inverse of their last value, so stale data never match.
   task automatic access(input logic rd, input logic [7:0] a, input logic [3:0] be,
                         input logic [7:0] wd, output logic [31:0] rdat);
      @(posedge i_mclk);
      o_address <= a;
      o_read <= rd;
      o_write <= !rd;
      o_byteenable <= be;
      o_writedata <= {24'h0, wd};
      // The slave is sampled only at rising edges, while the request stands.
      @(posedge i_mclk);
      while (i_waitrequest)
      begin
         @(posedge i_mclk);
      end
      rdat = i_readdata;
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_address <= ~a;
      o_writedata <= ~{24'h0, wd};
   endtask
endmodule

//--- verif/reader_mode_control_regs_tb_top.sv
// Self-checking bench for the reader mode control register bank.
// Assumes the host model is compiled first.
`timescale 1ns/100ps
module reader_mode_control_regs_tb_top;
   logic        i_mclk, i_nrst, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic [7:0]  i_avs_address, i_normal_rate;
   logic [3:0]  i_avs_byteenable, o_op_mode, o_tx_rate, o_rx_rate;
   logic [31:0] i_avs_writedata, o_avs_readdata, rdat;
   logic        i_field_on_cmd, i_tx_done, i_set_default_cmd, i_go_normal_cmd;
   logic        i_channel_choice, o_osc_reg_enable, o_rx_path_enable, o_tx_path_enable;
   logic        o_am_channel_en, o_pm_channel_en, o_auto_channel, o_use_pm_channel;
   logic        o_wakeup_mode, o_target_role, o_active_comm, o_auto_rca, o_config_ok;
   logic        o_tx_parity_off;
   int          miscompares, checked;
   reader_mode_control_regs i_dut
   (
      .i_mclk, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_byteenable,
      .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_field_on_cmd, .i_tx_done,
      .i_set_default_cmd, .i_go_normal_cmd, .i_normal_rate, .i_channel_choice,
      .o_osc_reg_enable, .o_rx_path_enable, .o_tx_path_enable, .o_am_channel_en,
      .o_pm_channel_en, .o_auto_channel, .o_use_pm_channel, .o_wakeup_mode, .o_target_role,
      .o_op_mode, .o_active_comm, .o_auto_rca, .o_tx_rate, .o_rx_rate, .o_config_ok,
      .o_tx_parity_off
   );
   avalon_host_model i_host
   (
      .i_mclk, .i_readdata(o_avs_readdata), .i_waitrequest(o_avs_waitrequest),
      .o_address(i_avs_address), .o_read(i_avs_read), .o_write(i_avs_write),
      .o_byteenable(i_avs_byteenable), .o_writedata(i_avs_writedata)
   );
   always #2.5 i_mclk = ~i_mclk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.access(1'b0, a, 4'h1, d, rdat);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      i_host.access(1'b1, a, 4'h1, 8'h00, rdat);
      chk(nm, rdat, {24'h0, e});
   endtask
   task automatic settle();
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
   endtask
   task automatic pulse(input logic [3:0] sel);
      @(posedge i_mclk);
      {i_go_normal_cmd, i_set_default_cmd, i_tx_done, i_field_on_cmd} <= sel;
      @(posedge i_mclk);
      {i_go_normal_cmd, i_set_default_cmd, i_tx_done, i_field_on_cmd} <= 4'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd("opctl", 8'h08, 8'h00);
      rd("mode", 8'h0C, 8'h08);
      rd("rate", 8'h10, 8'h00);
      rd("typea", 8'h14, 8'h00);
      rd("unmapped", 8'h18, 8'h00);
      rd("unaligned", 8'h0D, 8'h00);
      i_host.access(1'b0, 8'h0C, 4'h0, 8'hFF, rdat);
      rd("no lane", 8'h0C, 8'h08);
      chk("rst outs", 32'({o_op_mode, o_config_ok}), 32'h3);
   endtask
   task automatic t_opctl();
      logic [7:0] v [4];
      v = '{8'hFF, 8'h88, 8'h48, 8'h04};
      foreach (v[k])
      begin
         wr(8'h08, v[k]);
         rd("opctl", 8'h08, v[k] & 8'hFC);
         settle();
         chk("opctl outs", 32'({o_osc_reg_enable, o_rx_path_enable, o_tx_path_enable,
             o_wakeup_mode}), 32'({v[k][7], v[k][7] & v[k][6], v[k][7] & v[k][3],
             v[k][2]}));
      end
   endtask
   task automatic t_channels();
      for (int k = 0; k < 8; k++)
      begin
         @(posedge i_mclk);
         i_channel_choice <= k[0];
         wr(8'h08, {2'b11, k[2:1], 4'h0});
         settle();
         chk("channels", 32'({o_am_channel_en, o_pm_channel_en, o_auto_channel,
             o_use_pm_channel}), 32'({!k[2] | !k[0], !k[2] | k[0], !k[2] & !k[1],
             (k[2] | k[1]) & k[0]}));
      end
   endtask
   task automatic t_modes();
      logic ok;
      logic act;
      wr(8'h08, 8'hC8);
      for (int k = 0; k < 32; k++)
      begin
         ok = k[4] ? (k[3:0] < 2) : (k[3:0] < 5 || k[3:0] > 13);
         act = k[3:0] == 0 || (k[4] && k[3:0] == 1);
         wr(8'h0C, {k[4:0], 2'b00, k[0]});
         settle();
         chk("mode ok", 32'({o_config_ok, o_rx_path_enable, o_tx_path_enable}),
             32'({ok, ok, ok}));
         chk("active", 32'(o_active_comm), 32'(act));
         chk("mode outs", 32'({o_target_role, o_op_mode}), 32'(k[4:0]));
         chk("auto rca", 32'(o_auto_rca), 32'(k[0]));
      end
   endtask
   task automatic t_rates();
      logic [7:0] m [3];
      logic       ok;
      m = '{8'h10, 8'h08, 8'h00};
      foreach (m[j])
      begin
         wr(8'h0C, m[j]);
         for (int k = 0; k < 16; k++)
         begin
            ok = k < 4 || (m[j] == 8'h10 && k < 6);
            wr(8'h10, {k[3:0], k[3:0]});
            settle();
            chk("tx rate", 32'(o_tx_rate), 32'(k));
            chk("tx ok", 32'(o_config_ok), 32'(ok));
         end
      end
      wr(8'h0C, 8'h08);
      for (int k = 0; k < 16; k++)
      begin
         wr(8'h10, {4'h1, k[3:0]});
         settle();
         chk("rx rate", 32'(o_rx_rate), 32'(k));
         chk("rx ok", 32'(o_config_ok), 32'(k < 6));
      end
      wr(8'h0C, 8'h00);
      wr(8'h10, 8'h21);
      settle();
      chk("rx same", 32'({o_rx_rate, o_tx_rate}), 32'h22);
   endtask
   task automatic t_cmds();
      wr(8'h08, 8'h80);
      pulse(4'h1);
      rd("field on", 8'h08, 8'h88);
      pulse(4'h2);
      rd("tx done", 8'h08, 8'h80);
      wr(8'h0C, 8'h08);
      pulse(4'h1);
      pulse(4'h2);
      rd("tx kept", 8'h08, 8'h88);
      wr(8'h10, 8'h33);
      wr(8'h14, 8'hFF);
      settle();
      chk("parity", 32'(o_tx_parity_off), 32'h1);
      pulse(4'h4);
      rd("rate dflt", 8'h10, 8'h00);
      rd("typea dflt", 8'h14, 8'h00);
      rd("opctl kept", 8'h08, 8'h88);
      rd("mode kept", 8'h0C, 8'h08);
      pulse(4'h8);
      rd("go normal", 8'h10, 8'h12);
      wr(8'h10, 8'h55);
      pulse(4'hC);
      rd("go wins", 8'h10, 8'h12);
      wr(8'h0C, 8'h00);
      pulse(4'h3);
      rd("set wins", 8'h08, 8'h88);
   endtask
   task automatic final_report();
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_mclk = 1'b0;
      i_nrst = 1'b0;
      {i_field_on_cmd, i_tx_done, i_set_default_cmd, i_go_normal_cmd} = 4'h0;
      i_channel_choice = 1'b0;
      i_normal_rate = 8'h12;
      miscompares = 0;
      checked = 0;
      repeat (20) @(posedge i_mclk);
      i_nrst <= 1'b1;
      settle();
      t_reset();
      t_opctl();
      t_channels();
      t_modes();
      t_rates();
      t_cmds();
      final_report();
   end
   // The whole run needs well under a thousand cycles; this cuts a hung handshake short.
   initial
   begin
      #100us;
      miscompares++;
      final_report();
   end
endmodule
